//--- rtl/acs_pkg.sv
// constants and types for the converter sequencer control block
// assumes a single 100 MHz clock and an AHB-Lite register port
// Contract
// - four sequencers, depths eight, four, four, one
// - queue word: result in low ten bits
// - each step: input nibble plus control nibble
// - sequencer runs only while its enable set
// - any step may raise its sequencer interrupt
// - end flag stops sequence after that step
// - queue read returns oldest entry, removes it
// - status shows head, tail, full, empty
// - overflow and underflow recorded per sequencer
// - raw status unmasked; mask gates interrupt output
// - writing one clears interrupt; zero ignored
// - concurrent triggers served by priority, zero first
// - per-sequencer trigger source, processor, external and always
// - initiate write starts processor-triggered sequencers
// - averaging up to 64 conversions per entry
// - averaging off after reset, shared by all
// - single-ended codes 0x000 to 0x3FF
// - differential pair n uses inputs 2n, 2n+1
// - differential: even positive, zero difference 0x1FF
// - loopback test mode inside digital section
// - converter clock derived near 16.667 MHz
// - reset priorities: zero highest, three lowest
// - raw bit stays set until cleared
package acs_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int CONV_TARGET_HZ = 16_667_000;
  localparam int CONV_DIV = (CLK_HZ + CONV_TARGET_HZ / 2) / CONV_TARGET_HZ;
  localparam logic [2:0] DIV_LAST = 3'(CONV_DIV - 1);
  localparam logic [2:0] DIV_HALF = 3'(CONV_DIV / 2);
  localparam int NSEQ = 4;
  localparam int MAXD = 8;
  localparam int RES_W = 10;
  localparam logic [3:0][3:0] SEQ_DEPTH = {4'h1, 4'h4, 4'h4, 4'h8};
  localparam logic [8:0] OFF_ACTSS = 9'h000;
  localparam logic [8:0] OFF_RIS = 9'h004;
  localparam logic [8:0] OFF_IM = 9'h008;
  localparam logic [8:0] OFF_ISC = 9'h00C;
  localparam logic [8:0] OFF_OSTAT = 9'h010;
  localparam logic [8:0] OFF_EMUX = 9'h014;
  localparam logic [8:0] OFF_USTAT = 9'h018;
  localparam logic [8:0] OFF_SSPRI = 9'h020;
  localparam logic [8:0] OFF_PSSI = 9'h028;
  localparam logic [8:0] OFF_SAC = 9'h030;
  localparam logic [8:0] OFF_TMLB = 9'h100;
  localparam logic [8:0] SEQ_LO = 9'h040;
  localparam logic [8:0] SEQ_HI = 9'h0BF;
  localparam logic [4:0] SUB_MUX = 5'h00;
  localparam logic [4:0] SUB_CTL = 5'h04;
  localparam logic [4:0] SUB_FIFO = 5'h08;
  localparam logic [4:0] SUB_FST = 5'h0C;
  localparam logic [1:0] SEQ_IDX_OFS = 2'h2;
  localparam logic [15:0] SSPRI_RST = 16'h3210;
  localparam logic [15:0] SSPRI_MASK = 16'h3333;
  localparam logic [31:0] SCTL3_RST = 32'h0000_0002;
  localparam logic [2:0] SAC_MAX = 3'h6;
  localparam int CTL_DIFF = 0;
  localparam int CTL_END = 1;
  localparam int CTL_IE = 2;
  localparam int CTL_TS = 3;
  localparam int FST_HPTR = 4;
  localparam int FST_EMPTY = 8;
  localparam int FST_FULL = 12;
  localparam logic [3:0] TRIG_PROC = 4'h0;
  localparam logic [3:0] TRIG_EXT = 4'h1;
  localparam logic [3:0] TRIG_ALWAYS = 4'hF;
  typedef enum logic [1:0] {S_IDLE, S_START, S_WAIT} acs_st_e;
endpackage

//--- rtl/acs_top.sv
// sequencer control around a 10-bit converter core, AHB-Lite slave
// assumes converter core handshake on CLK_IN; TRIG_IN asynchronous
`timescale 1ns/100ps
`default_nettype none
module acs_top
  import acs_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic [3:0] TRIG_IN,
  output logic CONV_CLK_OUT,
  output logic CONV_START_OUT,
  output logic [3:0] CONV_POS_OUT,
  output logic [3:0] CONV_NEG_OUT,
  output logic CONV_DIFF_OUT,
  output logic CONV_TEMP_OUT,
  input wire logic CONV_DONE_IN,
  input wire logic [9:0] CONV_DATA_IN,
  output logic [3:0] IRQ_OUT
);
  typedef struct packed {
    logic ph_wr;
    logic ph_rd;
    logic [8:0] ph_addr;
    logic rdy;
    logic [31:0] rdata;
    logic [3:0] actss;
    logic [3:0] im;
    logic [3:0] ris;
    logic [3:0] ostat;
    logic [3:0] ustat;
    logic [3:0] pend;
    logic [3:0] trig1;
    logic [3:0] trig2;
    logic [3:0] trigp;
    logic [15:0] emux;
    logic [15:0] sspri;
    logic [2:0] sac;
    logic tmlb;
    logic [NSEQ-1:0][31:0] smux;
    logic [NSEQ-1:0][31:0] sctl;
    logic [NSEQ-1:0][MAXD-1:0][RES_W-1:0] mem;
    logic [NSEQ-1:0][2:0] head;
    logic [NSEQ-1:0][2:0] tail;
    logic [NSEQ-1:0][3:0] cnt;
    logic [2:0] div;
    logic cclk;
    acs_st_e st;
    logic [1:0] cur;
    logic [2:0] step;
    logic [15:0] acc;
    logic [6:0] nacc;
    logic start;
    logic [3:0] pos;
    logic [3:0] neg;
    logic diff;
    logic temp;
  } acs_state_s;

  acs_state_s r_q;
  acs_state_s r_d;
  logic tick;
  logic [1:0] sq;
  logic is_seq;
  logic [31:0] rd_val;
  logic [3:0] isc_clr;
  logic [3:0] pssi;
  logic [3:0] pop;
  logic [3:0] elig;
  logic found;
  logic [1:0] win;
  logic [1:0] bestp;
  logic [3:0] nib;
  logic [3:0] cn;
  logic push;
  logic [9:0] smp;
  logic [15:0] sum;
  logic [6:0] navg;
  logic last;

  assign tick = r_q.div == DIV_LAST;
  assign sq = 2'(r_q.ph_addr[6:5] - SEQ_IDX_OFS);
  assign is_seq = r_q.ph_addr >= SEQ_LO && r_q.ph_addr <= SEQ_HI;
  assign isc_clr = (r_q.ph_wr && r_q.ph_addr == OFF_ISC) ?
                   HWDATA_IN[3:0] : 4'h0;
  assign HRDATA_OUT = r_q.rdata;
  assign HREADYOUT_OUT = r_q.rdy;
  assign HRESP_OUT = 1'b0;
  assign CONV_CLK_OUT = r_q.cclk;
  assign CONV_START_OUT = r_q.start;
  assign CONV_POS_OUT = r_q.pos;
  assign CONV_NEG_OUT = r_q.neg;
  assign CONV_DIFF_OUT = r_q.diff;
  assign CONV_TEMP_OUT = r_q.temp;
  assign IRQ_OUT = r_q.ris & r_q.im;

  // register read view
  always_comb begin
    rd_val = 32'h0;
    case (r_q.ph_addr)
      OFF_ACTSS: rd_val[3:0] = r_q.actss;
      OFF_RIS: rd_val[3:0] = r_q.ris;
      OFF_IM: rd_val[3:0] = r_q.im;
      OFF_ISC: rd_val[3:0] = r_q.ris & r_q.im;
      OFF_OSTAT: rd_val[3:0] = r_q.ostat;
      OFF_EMUX: rd_val[15:0] = r_q.emux;
      OFF_USTAT: rd_val[3:0] = r_q.ustat;
      OFF_SSPRI: rd_val[15:0] = r_q.sspri;
      OFF_SAC: rd_val[2:0] = r_q.sac;
      OFF_TMLB: rd_val[0] = r_q.tmlb;
      default: begin
        if (is_seq) begin
          case (r_q.ph_addr[4:0])
            SUB_MUX: rd_val = r_q.smux[sq];
            SUB_CTL: rd_val = r_q.sctl[sq];
            SUB_FIFO: rd_val[RES_W-1:0] = r_q.mem[sq][r_q.head[sq]];
            SUB_FST: begin
              rd_val[2:0] = r_q.tail[sq];
              rd_val[FST_HPTR +: 3] = r_q.head[sq];
              rd_val[FST_EMPTY] = r_q.cnt[sq] == 4'h0;
              rd_val[FST_FULL] = r_q.cnt[sq] == SEQ_DEPTH[sq];
            end
            default: rd_val = 32'h0;
          endcase
        end
      end
    endcase
  end

  always_comb begin
    r_d = r_q;
    pssi = 4'h0;
    pop = 4'h0;
    push = 1'b0;
    found = 1'b0;
    win = 2'h0;
    bestp = 2'h3;
    nib = 4'h0;
    cn = 4'h0;
    smp = 10'h0;
    sum = 16'h0;
    navg = 7'h0;
    last = 1'b0;
    r_d.start = 1'b0;
    r_d.trig1 = TRIG_IN;
    r_d.trig2 = r_q.trig1;
    r_d.trigp = r_q.trig2;
    // converter clock divider, outputs high for the first half
    r_d.div = tick ? 3'h0 : 3'(r_q.div + 3'h1);
    r_d.cclk = r_d.div < DIV_HALF;

    // bus: reads take one wait state so they see earlier writes
    if (r_q.ph_rd) begin
      r_d.rdata = rd_val;
      r_d.rdy = 1'b1;
      r_d.ph_rd = 1'b0;
      if (is_seq && r_q.ph_addr[4:0] == SUB_FIFO) begin
        pop[sq] = 1'b1;
      end
    end
    if (r_q.ph_wr) begin
      case (r_q.ph_addr)
        OFF_ACTSS: r_d.actss = HWDATA_IN[3:0];
        OFF_IM: r_d.im = HWDATA_IN[3:0];
        OFF_ISC: r_d.ris = r_q.ris & ~isc_clr;
        OFF_OSTAT: r_d.ostat = r_q.ostat & ~HWDATA_IN[3:0];
        OFF_EMUX: r_d.emux = HWDATA_IN[15:0];
        OFF_USTAT: r_d.ustat = r_q.ustat & ~HWDATA_IN[3:0];
        OFF_SSPRI: r_d.sspri = HWDATA_IN[15:0] & SSPRI_MASK;
        OFF_PSSI: pssi = HWDATA_IN[3:0];
        OFF_SAC: r_d.sac = (HWDATA_IN[2:0] > SAC_MAX) ?
                           SAC_MAX : HWDATA_IN[2:0];
        OFF_TMLB: r_d.tmlb = HWDATA_IN[0];
        default: begin
          if (is_seq && r_q.ph_addr[4:0] == SUB_MUX) begin
            r_d.smux[sq] = HWDATA_IN;
          end else if (is_seq && r_q.ph_addr[4:0] == SUB_CTL) begin
            r_d.sctl[sq] = HWDATA_IN;
          end
        end
      endcase
    end
    if (HSEL_IN && HREADY_IN && HTRANS_IN[1]) begin
      r_d.ph_wr = HWRITE_IN;
      r_d.ph_rd = !HWRITE_IN;
      r_d.ph_addr = HADDR_IN[8:0];
      r_d.rdy = HWRITE_IN;
    end else if (HREADY_IN) begin
      r_d.ph_wr = 1'b0;
    end

    // fixed-priority pick; equal values fall back to lower index
    elig = r_q.pend & r_q.actss;
    for (int i = 0; i < NSEQ; i++) begin
      if (elig[i] && (!found || r_q.sspri[4*i +: 2] < bestp)) begin
        found = 1'b1;
        win = 2'(i);
        bestp = r_q.sspri[4*i +: 2];
      end
    end

    nib = r_q.smux[r_q.cur][4*r_q.step +: 4];
    cn = r_q.sctl[r_q.cur][4*r_q.step +: 4];
    last = cn[CTL_END] ||
           {1'b0, r_q.step} == 4'(SEQ_DEPTH[r_q.cur] - 4'h1);
    // loopback result tags sequencer, step, input and mode
    smp = r_q.tmlb ? {r_q.cur, r_q.step, r_q.pos, r_q.diff} :
                     CONV_DATA_IN;
    sum = 16'(r_q.acc + {6'h0, smp});
    navg = 7'(r_q.nacc + 7'h1);
    case (r_q.st)
      S_IDLE: begin
        if (tick && found) begin
          r_d.pend[win] = 1'b0;
          r_d.cur = win;
          r_d.step = 3'h0;
          r_d.acc = 16'h0;
          r_d.nacc = 7'h0;
          r_d.st = S_START;
        end
      end
      S_START: begin
        if (tick) begin
          r_d.pos = cn[CTL_DIFF] ? {nib[2:0], 1'b0} : nib;
          r_d.neg = {nib[2:0], 1'b1};
          r_d.diff = cn[CTL_DIFF];
          r_d.temp = cn[CTL_TS];
          r_d.start = !r_q.tmlb;
          r_d.st = S_WAIT;
        end
      end
      S_WAIT: begin
        if ((CONV_DONE_IN && !r_q.tmlb) || (r_q.tmlb && tick)) begin
          if (navg == (7'h1 << r_q.sac)) begin
            push = 1'b1;
            r_d.acc = 16'h0;
            r_d.nacc = 7'h0;
            if (cn[CTL_IE]) begin
              r_d.ris[r_q.cur] = 1'b1;
            end
            if (last) begin
              r_d.st = S_IDLE;
            end else begin
              r_d.step = 3'(r_q.step + 3'h1);
              r_d.st = S_START;
            end
          end else begin
            r_d.acc = sum;
            r_d.nacc = navg;
            r_d.st = S_START;
          end
        end
      end
      default: r_d.st = S_IDLE;
    endcase
    if (r_q.st != S_IDLE && !r_q.actss[r_q.cur]) begin
      r_d.st = S_IDLE;
      r_d.start = 1'b0;
    end

    // triggers; a new trigger beats the pending clear
    for (int i = 0; i < NSEQ; i++) begin
      case (r_q.emux[4*i +: 4])
        TRIG_PROC: if (pssi[i]) r_d.pend[i] = 1'b1;
        TRIG_EXT: if (r_q.trig2[i] && !r_q.trigp[i]) r_d.pend[i] = 1'b1;
        TRIG_ALWAYS: r_d.pend[i] = 1'b1;
        default: r_d.pend[i] = r_d.pend[i];
      endcase
      if (!r_q.actss[i]) begin
        r_d.pend[i] = 1'b0;
      end
    end

    // result queues
    for (int i = 0; i < NSEQ; i++) begin
      if (pop[i] && r_q.cnt[i] == 4'h0) begin
        r_d.ustat[i] = 1'b1;
      end else if (pop[i]) begin
        r_d.head[i] = ({1'b0, r_q.head[i]} == 4'(SEQ_DEPTH[i] - 4'h1)) ?
                      3'h0 : 3'(r_q.head[i] + 3'h1);
      end
      if (push && r_q.cur == 2'(i)) begin
        if (r_q.cnt[i] == SEQ_DEPTH[i]) begin
          r_d.ostat[i] = 1'b1;
        end else begin
          r_d.mem[i][r_q.tail[i]] = r_q.sac == 3'h0 ? smp :
                                    10'(sum >> r_q.sac);
          r_d.tail[i] = ({1'b0, r_q.tail[i]} ==
                         4'(SEQ_DEPTH[i] - 4'h1)) ?
                        3'h0 : 3'(r_q.tail[i] + 3'h1);
        end
      end
      r_d.cnt[i] = 4'(r_q.cnt[i]
        + {3'h0, push && r_q.cur == 2'(i) && r_q.cnt[i] != SEQ_DEPTH[i]}
        - {3'h0, pop[i] && r_q.cnt[i] != 4'h0});
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      r_q <= '0;
      r_q.rdy <= 1'b1;
      r_q.sspri <= SSPRI_RST;
      r_q.sctl[3] <= SCTL3_RST;
    end else begin
      r_q <= r_d;
    end
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);

  property p_depth;
    r_q.cnt[3] <= SEQ_DEPTH[3] && r_q.cnt[2] <= SEQ_DEPTH[2] &&
    r_q.cnt[1] <= SEQ_DEPTH[1] && r_q.cnt[0] <= SEQ_DEPTH[0];
  endproperty
  a_depth: assert property (p_depth) else $error("queue over depth");

  property p_lsb;
    (HREADYOUT_OUT && $past(r_q.ph_rd) && is_seq &&
     r_q.ph_addr[4:0] == SUB_FIFO) |-> HRDATA_OUT[31:10] == 22'h0;
  endproperty
  a_lsb: assert property (p_lsb) else $error("queue word upper bits");

  property p_enable;
    (r_q.st != S_IDLE && !r_q.actss[r_q.cur]) |=>
      r_q.st == S_IDLE && !CONV_START_OUT;
  endproperty
  a_enable: assert property (p_enable) else $error("disabled seq ran");

  property p_ptr;
    (r_q.cnt[0] == 4'h0 || r_q.cnt[0] == SEQ_DEPTH[0]) |->
      r_q.head[0] == r_q.tail[0];
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer mismatch");

  property p_mask;
    (r_q.ris[1] && !r_q.im[1]) |-> !IRQ_OUT[1];
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq seen");

  property p_ris_hold;
    $fell(r_q.ris[0]) |-> $past(isc_clr[0]);
  endproperty
  a_ris_hold: assert property (p_ris_hold) else $error("raw bit lost");

  property p_tick;
    tick |=> !tick [*5] ##1 tick;
  endproperty
  a_tick: assert property (p_tick) else $error("divider period");

  property p_start;
    CONV_START_OUT |-> r_q.st == S_WAIT && $past(r_q.st) == S_START;
  endproperty
  a_start: assert property (p_start) else $error("stray start");

  property p_udf;
    (pop[0] && r_q.cnt[0] == 4'h0) |=>
      r_q.ustat[0] && $stable(r_q.head[0]);
  endproperty
  a_udf: assert property (p_udf) else $error("underflow handling");
endmodule
`default_nettype wire

//--- dv/acs_conv_model.sv
// behavioural converter core facing the sequencer control block
// assumes start pulses and input selects on the block's clock
`timescale 1ns/100ps
`default_nettype none
module acs_conv_model (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic start_in,
  input wire logic [3:0] pos_in,
  input wire logic [3:0] neg_in,
  input wire logic diff_in,
  output logic done_out,
  output logic [9:0] data_out
);
  logic busy;
  int unsigned wait_n;
  // latency varies from prompt to slow on every conversion
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy <= 1'b0;
      done_out <= 1'b0;
      data_out <= 10'h2AA;
    end else begin
      done_out <= 1'b0;
      // result lines are not held outside the done pulse
      data_out <= ~data_out;
      if (start_in) begin
        busy <= 1'b1;
        wait_n <= $urandom_range(1, 40);
      end else if (busy && wait_n > 1) begin
        wait_n <= wait_n - 1;
      end else if (busy) begin
        busy <= 1'b0;
        done_out <= 1'b1;
        // code tracks the selected inputs, pair polarity included
        data_out <= {pos_in, diff_in ? neg_in : 4'h5, diff_in, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// top-level bench: AHB-Lite master tasks, converter model, scenarios
// assumes hready loops back from the block and a single 100 MHz clock
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import acs_pkg::*;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, rdy, done, start, diff;
  logic hresp, cclk, temp;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
  logic [3:0] trig = 4'h0, pos, neg, irq;
  logic [9:0] cdata;
  logic [3:0] pos_q[$];
  int n_mismatch = 0, total_checks = 0;
  always #5 clk = ~clk;
  acs_top dut (
    .CLK_IN(clk), .ARST_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwdata), .HREADY_IN(rdy), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(rdy), .HRESP_OUT(hresp), .TRIG_IN(trig),
    .CONV_CLK_OUT(cclk), .CONV_START_OUT(start), .CONV_POS_OUT(pos),
    .CONV_NEG_OUT(neg), .CONV_DIFF_OUT(diff), .CONV_TEMP_OUT(temp),
    .CONV_DONE_IN(done), .CONV_DATA_IN(cdata), .IRQ_OUT(irq));
  acs_conv_model u_conv (.clk_in(clk), .arst_n_in(rst_n), .start_in(start),
    .pos_in(pos), .neg_in(neg), .diff_in(diff), .done_out(done),
    .data_out(cdata));
  // start is a one-cycle pulse, so mid-cycle sampling sees it once
  always @(negedge clk) if (start === 1'b1) pos_q.push_back(pos);
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic waitrdy();
    int n = 0;
    do begin
      @(negedge clk);
      rv = hrdata;
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
    @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {23'h0, a};
    hwrite <= w;
    waitrdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitrdy();
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input logic [8:0] a, input logic [31:0] e,
                      input string w, input logic [31:0] m = 32'hFFFFFFFF);
    bus(1'b0, a, 32'h0);
    chk(rv & m, e, w);
  endtask
  function automatic logic [8:0] sb(input int s, input logic [4:0] sub);
    return SEQ_LO + 9'(32 * s) + {4'h0, sub};
  endfunction
  function automatic logic [31:0] ecode(input logic [3:0] p, n, input logic d);
    return {22'h0, p, d ? n : 4'h5, d, 1'b1};
  endfunction
  task automatic wait_ris(input int b);
    int n = 0;
    do begin
      bus(1'b0, OFF_RIS, 32'h0);
      n++;
    end while (rv[b] !== 1'b1 && n < 300);
    if (rv[b] !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  // configure while disabled, then enable and start by software
  task automatic run(input int s, input logic [31:0] mux, ctl);
    wr(OFF_ACTSS, 32'h0);
    wr(sb(s, SUB_MUX), mux);
    wr(sb(s, SUB_CTL), ctl);
    wr(OFF_ACTSS, 32'(1 << s));
    pos_q.delete();
    wr(OFF_PSSI, 32'(1 << s));
    wait_ris(s);
  endtask
  initial begin
    logic [3:0] p;
    logic [31:0] mx, ct;
    int k;
    void'($urandom(14834));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk(OFF_SSPRI, 32'h3210, "priority reset");
    rchk(sb(3, SUB_CTL), SCTL3_RST, "ctl3 reset");
    rchk(OFF_SAC, 32'h0, "averaging reset");
    for (int i = 0; i < 4; i++) rchk(sb(i, SUB_FST), 32'h100, "fst reset");
    wr(9'h1FC, 32'hFFFFFFFF);
    rchk(9'h1FC, 32'h0, "unmapped");
    chk({31'h0, hresp}, 32'h0, "response okay");
    // two converter clock periods of six system clocks, half of them high
    k = 0;
    repeat (12) begin
      @(negedge clk);
      k += int'(cclk);
    end
    @(posedge clk);
    chk(32'(k), 32'h6, "converter clock duty");
    $display("test reset values done");
    wr(OFF_PSSI, 32'h2);
    repeat (40) @(posedge clk);
    chk(32'(pos_q.size()), 32'h0, "disabled runs");
    p = 4'($urandom_range(0, 5));
    run(3, {28'h0, p}, 32'h6);
    chk({28'h0, irq}, 32'h0, "irq masked");
    wr(OFF_IM, 32'h8);
    rchk(OFF_ISC, 32'h8, "masked status");
    chk({28'h0, irq}, 32'h8, "irq unmasked");
    wr(OFF_ISC, 32'h0);
    rchk(OFF_RIS, 32'h8, "zero write keeps");
    wr(OFF_ISC, 32'h8);
    rchk(OFF_RIS, 32'h0, "one write clears");
    rchk(sb(3, SUB_FIFO), ecode(p, 4'h0, 1'b0), "seq3 data", 32'h3FF);
    rchk(sb(3, SUB_FST), 32'h100, "seq3 empty", 32'h1100);
    wr(OFF_IM, 32'h0);
    $display("test interrupts done");
    for (int r = 0; r < 2; r++) begin
      k = (r == 0) ? 7 : $urandom_range(0, 6);
      for (int i = 0; i < 8; i++) begin
        mx[4*i +: 4] = 4'($urandom_range(0, 5));
        ct[4*i +: 4] = i < k ? 4'h0 : (i == k ? 4'h6 : 4'($urandom()));
      end
      run(0, mx, ct);
      wr(OFF_ISC, 32'h1);
      chk(32'(pos_q.size()), 32'(k + 1), "steps run");
      rchk(sb(0, SUB_FST), k == 7 ? 32'h1000 : 32'h0, "fill", 32'h1100);
      for (int i = 0; i <= k; i++) begin
        chk({28'h0, pos_q[i]}, {28'h0, mx[4*i +: 4]}, "step order");
        rchk(sb(0, SUB_FIFO), ecode(mx[4*i +: 4], 4'h0, 1'b0), "fifo order",
             32'h3FF);
      end
      rchk(sb(0, SUB_FST), 32'h100, "drained", 32'h1100);
      bus(1'b0, sb(0, SUB_FIFO), 32'h0);
      rchk(OFF_USTAT, 32'h1, "underflow");
      wr(OFF_USTAT, 32'h1);
      rchk(OFF_USTAT, 32'h0, "underflow cleared");
    end
    $display("test sequence end done");
    run(3, 32'h1, 32'h6);
    wr(OFF_ISC, 32'h8);
    run(3, 32'h2, 32'h6);
    wr(OFF_ISC, 32'h8);
    rchk(OFF_OSTAT, 32'h8, "overflow");
    rchk(sb(3, SUB_FIFO), ecode(4'h1, 4'h0, 1'b0), "kept", 32'h3FF);
    wr(OFF_OSTAT, 32'h8);
    rchk(OFF_OSTAT, 32'h0, "overflow cleared");
    $display("test overflow done");
    for (int n = 0; n < 4; n++) begin
      run(2, 32'(n), 32'h7);
      wr(OFF_ISC, 32'h4);
      chk({28'h0, neg}, 32'(2 * n + 1), "odd negative");
      rchk(sb(2, SUB_FIFO), ecode(4'(2 * n), 4'(2 * n + 1), 1'b1), "pair",
           32'h3FF);
    end
    $display("test differential done");
    wr(OFF_TMLB, 32'h1);
    p = 4'($urandom_range(0, 5));
    run(1, {28'h0, p}, 32'h6);
    wr(OFF_ISC, 32'h2);
    chk(32'(pos_q.size()), 32'h0, "loopback no start");
    rchk(sb(1, SUB_FIFO), {22'h0, 2'h1, 3'h0, p, 1'b0}, "loopback",
         32'h3FF);
    wr(OFF_TMLB, 32'h0);
    $display("test loopback done");
    wr(OFF_SAC, 32'h7);
    rchk(OFF_SAC, 32'h6, "averaging clamp", 32'h7);
    wr(OFF_SAC, 32'h2);
    run(3, {28'h0, p}, 32'hE);
    wr(OFF_ISC, 32'h8);
    chk(32'(pos_q.size()), 32'h4, "averaged count");
    chk({31'h0, temp}, 32'h1, "temperature select");
    rchk(sb(3, SUB_FIFO), ecode(p, 4'h0, 1'b0), "average", 32'h3FF);
    wr(OFF_SAC, 32'h0);
    $display("test averaging done");
    wr(OFF_ACTSS, 32'h0);
    wr(sb(1, SUB_MUX), 32'h1);
    wr(sb(2, SUB_MUX), 32'h4);
    wr(sb(2, SUB_CTL), 32'h6);
    wr(OFF_SSPRI, 32'h3012);
    wr(OFF_ACTSS, 32'h6);
    pos_q.delete();
    wr(OFF_PSSI, 32'h6);
    wait_ris(1);
    wait_ris(2);
    chk({28'h0, pos_q[0]}, 32'h4, "priority order");
    wr(OFF_ISC, 32'hF);
    $display("test priority done");
    wr(OFF_ACTSS, 32'h0);
    wr(OFF_EMUX, 32'h1F00);
    // external source on top, else the always source starves it
    wr(OFF_SSPRI, 32'h0312);
    wr(OFF_ACTSS, 32'hC);
    trig <= 4'h8;
    wait_ris(2);
    wr(OFF_ISC, 32'h4);
    wait_ris(3);
    wr(OFF_ACTSS, 32'h0);
    chk({31'h0, rv[3]}, 32'h1, "external trigger");
    rchk(sb(3, SUB_FIFO), ecode(p, 4'h0, 1'b0), "external result",
         32'h3FF);
    $display("test triggers done");
    report_and_stop();
  end
endmodule
`default_nettype wire
